// [rtl/ipf_pkg.sv]
// Constants for the interrupt priority field bank: register indices,
// field positions, reset value and priority codes.
// Assumes nothing beyond a SystemVerilog elaborator.
package ipf_pkg;

  // ********************************************************
  // Bus and field widths
  // ********************************************************
  localparam int IPF_AW = 3;
  localparam int IPF_DW = 16;
  localparam int IPF_PW = 3;
  localparam int IPF_NSRC = 9;
  localparam int IPF_SW = 4;

  // ********************************************************
  // Register indices
  // ********************************************************
  localparam logic [IPF_AW-1:0] IPF_IDX_CTRL2 = 3'h0;
  localparam logic [IPF_AW-1:0] IPF_IDX_CTRL3 = 3'h1;
  localparam logic [IPF_AW-1:0] IPF_IDX_CTRL4 = 3'h2;
  localparam logic [IPF_AW-1:0] IPF_IDX_TAKE = 3'h3;
  localparam logic [IPF_AW-1:0] IPF_IDX_OFF = 3'h4;

  // ********************************************************
  // Source numbers; a lower number wins a tie
  // ********************************************************
  localparam int IPF_SRC_NVM = 0;
  localparam int IPF_SRC_AD = 1;
  localparam int IPF_SRC_TX1 = 2;
  localparam int IPF_SRC_CN = 3;
  localparam int IPF_SRC_CMP = 4;
  localparam int IPF_SRC_BCL = 5;
  localparam int IPF_SRC_SSP = 6;
  localparam int IPF_SRC_CCP5 = 7;
  localparam int IPF_SRC_INT1 = 8;

  // ********************************************************
  // Field low bit positions
  // ********************************************************
  localparam int IPF_LSB_NVM = 12;
  localparam int IPF_LSB_AD = 4;
  localparam int IPF_LSB_TX1 = 0;
  localparam int IPF_LSB_CN = 12;
  localparam int IPF_LSB_CMP = 8;
  localparam int IPF_LSB_BCL = 4;
  localparam int IPF_LSB_SSP = 0;
  localparam int IPF_LSB_CCP5 = 8;
  localparam int IPF_LSB_INT1 = 0;

  // Per-source register and position, indexed by source number
  localparam logic [IPF_AW-1:0] IPF_SRC_REG [IPF_NSRC] = '{
    IPF_IDX_CTRL2, IPF_IDX_CTRL2, IPF_IDX_CTRL2,
    IPF_IDX_CTRL3, IPF_IDX_CTRL3, IPF_IDX_CTRL3, IPF_IDX_CTRL3,
    IPF_IDX_CTRL4, IPF_IDX_CTRL4};
  localparam int IPF_SRC_LSB [IPF_NSRC] = '{
    IPF_LSB_NVM, IPF_LSB_AD, IPF_LSB_TX1,
    IPF_LSB_CN, IPF_LSB_CMP, IPF_LSB_BCL, IPF_LSB_SSP,
    IPF_LSB_CCP5, IPF_LSB_INT1};

  // ********************************************************
  // Priority codes and reset value
  // ********************************************************
  localparam logic [IPF_PW-1:0] IPF_PRIO_OFF = 3'h0;
  localparam logic [IPF_PW-1:0] IPF_PRIO_MIN = 3'h1;
  localparam logic [IPF_PW-1:0] IPF_PRIO_MAX = 3'h7;
  localparam logic [IPF_PW-1:0] IPF_PRIO_RST = 3'h4;

  // Take status layout
  localparam int IPF_TAKE_LVL_LSB = 0;
  localparam int IPF_TAKE_SRC_LSB = 4;
  localparam int IPF_TAKE_VLD_BIT = 8;

  typedef logic [IPF_NSRC-1:0][IPF_PW-1:0] ipf_prio_vec_t;

endpackage

// [rtl/ipf_arbiter.sv]
// Picks the pending, enabled source with the highest nonzero priority.
// Assumes priorities, pending and enable inputs synchronous to clk_i.
`timescale 1ns/10ps
`default_nettype none
module ipf_arbiter
  import ipf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ipf_prio_vec_t prio_i,
  input wire logic [IPF_NSRC-1:0] pend_i,
  input wire logic [IPF_NSRC-1:0] en_i,
  output logic valid_o,
  output logic [IPF_SW-1:0] src_o,
  output logic [IPF_PW-1:0] level_o
);

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    logic valid;
    logic [IPF_SW-1:0] src;
    logic [IPF_PW-1:0] level;
  } ipf_arb_state_t;

  ipf_arb_state_t q;
  ipf_arb_state_t d;

  // Strict greater-than keeps the lowest source number on a tie
  always_comb begin
    d = q;
    d.valid = 1'b0;
    d.src = '0;
    d.level = IPF_PRIO_OFF;
    for (int s = 0; s < IPF_NSRC; s++) begin
      if (pend_i[s] && en_i[s] && prio_i[s] != IPF_PRIO_OFF
          && prio_i[s] > d.level) begin
        d.valid = 1'b1;
        d.src = IPF_SW'(s);
        d.level = prio_i[s];
      end
    end
  end

  // Result registered so it is glitch free for the core
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign valid_o = q.valid;
  assign src_o = q.src;
  assign level_o = q.level;

  // ********************************************************
  // Checks per source
  // ********************************************************
  for (genvar s = 0; s < IPF_NSRC; s++) begin : g_chk
    chk_taken_level: assert property (@(posedge clk_i) disable iff (rst_i)
      (valid_o && src_o == IPF_SW'(s)) |-> (level_o == $past(prio_i[s])
      && $past(prio_i[s]) != IPF_PRIO_OFF && $past(pend_i[s] && en_i[s])))
      else $error("taken level differs from field code");
    chk_best_wins: assert property (@(posedge clk_i) disable iff (rst_i)
      valid_o |-> !($past(pend_i[s] && en_i[s]) && $past(prio_i[s]) > level_o))
      else $error("higher priority source passed over");
  end

  // Sources the rules allow to be taken; code 001 still counts as live
  logic [IPF_NSRC-1:0] live_vec;
  for (genvar s = 0; s < IPF_NSRC; s++) begin : g_live
    assign live_vec[s] = pend_i[s] && en_i[s] && prio_i[s] != IPF_PRIO_OFF;
  end

  // Skip the edge after reset, when the result register is still cleared
  chk_none_lost: assert property (@(posedge clk_i) disable iff (rst_i)
    (!$past(rst_i) && $past(live_vec) != '0) |-> valid_o)
    else $error("eligible source not taken");

  chk_idle_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(live_vec) == '0 |-> !valid_o)
    else $error("source taken with none eligible");

endmodule
`default_nettype wire

// [rtl/ipf_top.sv]
// Interrupt priority field bank: nine 3-bit priority fields in three
// registers, a small register port, and the arbiter that uses them.
// Assumes one clock, synchronous active-high reset, and a master that
// never issues read and write strobes together.
//
// Contract
// - code 111 means priority level seven
// - code 001 means priority level one
// - code 000 disables its source entirely
// - unused bits read zero, ignore writes
// - every field resets to 100, read-write
// - change notify field at ctrl3 14:12
// - comparator field at ctrl3 10:8
// - bus collision field at ctrl3 6:4
// - sync port event field at ctrl3 2:0
// - capture compare5 field at ctrl4 10:8
// - external pin1 field at ctrl4 2:0
`timescale 1ns/10ps
`default_nettype none
module ipf_top
  import ipf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [IPF_AW-1:0] addr_i,
  input wire logic [IPF_DW-1:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [IPF_DW-1:0] rdata_o,
  input wire logic [IPF_NSRC-1:0] src_pend_i,
  input wire logic [IPF_NSRC-1:0] src_en_i,
  output logic [IPF_PW-1:0] nonvolatile_memory_priority_o,
  output logic [IPF_PW-1:0] analog_conversion_priority_o,
  output logic [IPF_PW-1:0] serial1_transmit_priority_o,
  output logic [IPF_PW-1:0] change_notify_priority_o,
  output logic [IPF_PW-1:0] comparator_priority_o,
  output logic [IPF_PW-1:0] bus_collision_priority_o,
  output logic [IPF_PW-1:0] sync_port_event_priority_o,
  output logic [IPF_PW-1:0] capture_compare5_priority_o,
  output logic [IPF_PW-1:0] external_pin1_priority_o,
  output logic take_valid_o,
  output logic [IPF_SW-1:0] take_src_o,
  output logic [IPF_PW-1:0] take_level_o
);

  // ********************************************************
  // Address decode helpers
  // ********************************************************

  // True when source s lives in register idx
  function automatic logic ipf_hit(input logic [IPF_AW-1:0] idx, input int s);
    return idx == IPF_SRC_REG[s];
  endfunction

  // Packs the fields of one register; other bits stay zero
  function automatic logic [IPF_DW-1:0] ipf_pack(input logic [IPF_AW-1:0] idx,
                                                 input ipf_prio_vec_t p);
    logic [IPF_DW-1:0] w;
    w = '0;
    for (int s = 0; s < IPF_NSRC; s++) begin
      if (ipf_hit(idx, s)) begin
        w[IPF_SRC_LSB[s] +: IPF_PW] = p[s];
      end
    end
    return w;
  endfunction

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    ipf_prio_vec_t prio;
    logic [IPF_DW-1:0] rdata;
  } ipf_state_t;

  ipf_state_t q;
  ipf_state_t d;
  ipf_prio_vec_t all_ones;
  logic [IPF_NSRC-1:0] off_vec;
  logic arb_valid;
  logic [IPF_SW-1:0] arb_src;
  logic [IPF_PW-1:0] arb_level;

  assign all_ones = '1;

  // Sources whose field holds the disable code
  for (genvar s = 0; s < IPF_NSRC; s++) begin : g_off
    assign off_vec[s] = q.prio[s] == IPF_PRIO_OFF;
  end

  // ********************************************************
  // Register port
  // ********************************************************

  // Writes touch only field bits; read data live for one cycle only
  always_comb begin
    d = q;
    for (int s = 0; s < IPF_NSRC; s++) begin
      if (we_i && ipf_hit(addr_i, s)) begin
        d.prio[s] = wdata_i[IPF_SRC_LSB[s] +: IPF_PW];
      end
    end
    d.rdata = '0;
    if (re_i) begin
      if (addr_i == IPF_IDX_CTRL2 || addr_i == IPF_IDX_CTRL3
          || addr_i == IPF_IDX_CTRL4) begin
        d.rdata = ipf_pack(addr_i, q.prio);
      end else if (addr_i == IPF_IDX_TAKE) begin
        d.rdata[IPF_TAKE_LVL_LSB +: IPF_PW] = arb_level;
        d.rdata[IPF_TAKE_SRC_LSB +: IPF_SW] = arb_src;
        d.rdata[IPF_TAKE_VLD_BIT] = arb_valid;
      end else if (addr_i == IPF_IDX_OFF) begin
        d.rdata[IPF_NSRC-1:0] = off_vec;
      end
    end
  end

  // Fields start at level four so no source is disabled after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '{prio: {IPF_NSRC{IPF_PRIO_RST}}, rdata: '0};
    end else begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;

  // ********************************************************
  // Field outputs to the interrupt core
  // ********************************************************

  // Code is the level itself, so no translation is needed
  assign nonvolatile_memory_priority_o = q.prio[IPF_SRC_NVM];
  assign analog_conversion_priority_o = q.prio[IPF_SRC_AD];
  assign serial1_transmit_priority_o = q.prio[IPF_SRC_TX1];
  assign change_notify_priority_o = q.prio[IPF_SRC_CN];
  assign comparator_priority_o = q.prio[IPF_SRC_CMP];
  assign bus_collision_priority_o = q.prio[IPF_SRC_BCL];
  assign sync_port_event_priority_o = q.prio[IPF_SRC_SSP];
  assign capture_compare5_priority_o = q.prio[IPF_SRC_CCP5];
  assign external_pin1_priority_o = q.prio[IPF_SRC_INT1];

  // ********************************************************
  // Arbitration
  // ********************************************************

  // Uses the stored fields, so a write affects the next pick
  ipf_arbiter u_arb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .prio_i(q.prio),
    .pend_i(src_pend_i),
    .en_i(src_en_i),
    .valid_o(arb_valid),
    .src_o(arb_src),
    .level_o(arb_level)
  );

  assign take_valid_o = arb_valid;
  assign take_src_o = arb_src;
  assign take_level_o = arb_level;

  // ********************************************************
  // Checks
  // ********************************************************

  chk_reset_fields: assert property (@(posedge clk_i)
    $past(rst_i) && !rst_i |-> q.prio == {IPF_NSRC{IPF_PRIO_RST}})
    else $error("field not at reset level after reset");

  chk_unused_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(re_i && addr_i <= IPF_IDX_CTRL4)
    |-> (rdata_o & ~ipf_pack($past(addr_i), all_ones)) == '0)
    else $error("unimplemented bit read back nonzero");

  chk_read_window: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(re_i) |-> rdata_o == '0)
    else $error("read data outside the read cycle");

  chk_cn_field: assert property (@(posedge clk_i) disable iff (rst_i)
    (we_i && addr_i == IPF_IDX_CTRL3) |=> change_notify_priority_o
    == $past(wdata_i[IPF_LSB_CN +: IPF_PW]))
    else $error("change notify field misplaced");

  chk_cmp_field: assert property (@(posedge clk_i) disable iff (rst_i)
    (we_i && addr_i == IPF_IDX_CTRL3) |=> comparator_priority_o
    == $past(wdata_i[IPF_LSB_CMP +: IPF_PW]))
    else $error("comparator field misplaced");

  chk_bcl_field: assert property (@(posedge clk_i) disable iff (rst_i)
    (we_i && addr_i == IPF_IDX_CTRL3) |=> bus_collision_priority_o
    == $past(wdata_i[IPF_LSB_BCL +: IPF_PW]))
    else $error("bus collision field misplaced");

  chk_ssp_field: assert property (@(posedge clk_i) disable iff (rst_i)
    (we_i && addr_i == IPF_IDX_CTRL3) |=> sync_port_event_priority_o
    == $past(wdata_i[IPF_LSB_SSP +: IPF_PW]))
    else $error("sync port field misplaced");

  chk_ccp5_field: assert property (@(posedge clk_i) disable iff (rst_i)
    (we_i && addr_i == IPF_IDX_CTRL4) |=> capture_compare5_priority_o
    == $past(wdata_i[IPF_LSB_CCP5 +: IPF_PW]))
    else $error("capture compare field misplaced");

  chk_int1_field: assert property (@(posedge clk_i) disable iff (rst_i)
    (we_i && addr_i == IPF_IDX_CTRL4) |=> external_pin1_priority_o
    == $past(wdata_i[IPF_LSB_INT1 +: IPF_PW]))
    else $error("external pin field misplaced");

  chk_field_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !we_i |=> q.prio == $past(q.prio))
    else $error("field changed without a write");

  chk_max_level: assert property (@(posedge clk_i) disable iff (rst_i)
    take_valid_o |-> take_level_o >= IPF_PRIO_MIN && take_level_o <= IPF_PRIO_MAX)
    else $error("taken level out of range");

  chk_off_silent: assert property (@(posedge clk_i) disable iff (rst_i)
    (take_valid_o && take_src_o < IPF_SW'(IPF_NSRC))
    |-> ($past(off_vec) & (IPF_NSRC'(1) << take_src_o)) == '0)
    else $error("disabled source was taken");

endmodule
`default_nettype wire

// [tb/test_ipf_top.sv]
// Self-checking bench for the priority field bank: register access,
// field placement, reset values and selection by field code.
// Assumes ipf_pkg and ipf_top are compiled ahead of this file.
`timescale 1ns/10ps
`default_nettype none
module test_ipf_top
  import ipf_pkg::*;
;
  logic clk_i;
  logic rst_i;
  logic [IPF_AW-1:0] addr_i;
  logic [IPF_DW-1:0] wdata_i;
  logic we_i;
  logic re_i;
  logic [IPF_DW-1:0] rdata_o;
  logic [IPF_NSRC-1:0] src_pend_i;
  logic [IPF_NSRC-1:0] src_en_i;
  logic [IPF_PW-1:0] f0, f1, f2, f3, f4, f5, f6, f7, f8;
  logic take_valid_o;
  logic [IPF_SW-1:0] take_src_o;
  logic [IPF_PW-1:0] take_level_o;
  wire logic [26:0] all_f = {f0, f1, f2, f3, f4, f5, f6, f7, f8};
  wire logic [7:0] take_w = {take_valid_o, take_src_o, take_level_o};
  int errors;
  int checks;
  logic [2:0] lvl;
  logic [3:0] src;

  ipf_top dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
    .src_pend_i(src_pend_i), .src_en_i(src_en_i),
    .nonvolatile_memory_priority_o(f0), .analog_conversion_priority_o(f1),
    .serial1_transmit_priority_o(f2), .change_notify_priority_o(f3),
    .comparator_priority_o(f4), .bus_collision_priority_o(f5),
    .sync_port_event_priority_o(f6), .capture_compare5_priority_o(f7),
    .external_pin1_priority_o(f8), .take_valid_o(take_valid_o),
    .take_src_o(take_src_o), .take_level_o(take_level_o)
  );

  // ********************************************************
  // Clock and shared tasks
  // ********************************************************
  // Free running 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // One comparison; any unknown counts as a mismatch
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // Single-cycle write; fields are settled 1 ns after the strobe edge
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
    #1;
  endtask

  // Single-cycle read; data stands only in the following cycle
  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1;
    chk("rdata", {16'h0000, exp}, {16'h0000, rdata_o});
  endtask

  task automatic finish_test;
    if (errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    rst_i = 1'b1;
    addr_i = 3'h0;
    wdata_i = 16'h0000;
    we_i = 1'b0;
    re_i = 1'b0;
    src_pend_i = 9'h1FF;
    src_en_i = 9'h1FF;
    errors = 0;
    checks = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk("fields", {5'h00, {9{3'h4}}}, {5'h00, all_f});
    chk("take_rst", 32'h0, {24'h0, take_w});
    @(posedge clk_i);
    #1;
    chk("take", {24'h0, 8'h84}, {24'h0, take_w});
    rd(IPF_IDX_CTRL2, 16'h4044);
    @(posedge clk_i);
    #1;
    chk("rdata_idle", 32'h0, {16'h0000, rdata_o});
    rd(IPF_IDX_CTRL3, 16'h4444);
    rd(IPF_IDX_CTRL4, 16'h0404);
    // All-ones writes show which bits are implemented
    wr(IPF_IDX_CTRL2, 16'hFFFF);
    rd(IPF_IDX_CTRL2, 16'h7077);
    wr(IPF_IDX_CTRL3, 16'hFFFF);
    rd(IPF_IDX_CTRL3, 16'h7777);
    wr(IPF_IDX_CTRL4, 16'hFFFF);
    rd(IPF_IDX_CTRL4, 16'h0707);
    // Distinct codes per field prove placement
    wr(IPF_IDX_CTRL3, 16'h9AB4);
    chk("ctrl3_fields", 32'h29C, {20'h0, f3, f4, f5, f6});
    rd(IPF_IDX_CTRL3, 16'h1234);
    wr(IPF_IDX_CTRL4, 16'hF5F6);
    chk("ctrl4_fields", 32'h2E, {26'h0, f7, f8});
    rd(IPF_IDX_CTRL4, 16'h0506);
    // Writes to status and unmapped places change nothing
    wr(IPF_IDX_TAKE, 16'h0000);
    wr(IPF_IDX_OFF, 16'hFFFF);
    wr(3'h7, 16'h0000);
    chk("fields_kept", {5'h00, 27'h7FCA72E}, {5'h00, all_f});
    rd(3'h7, 16'h0000);
    // Only change notify and pin 1 compete; pin 1 held at 4
    wr(IPF_IDX_CTRL2, 16'h0000);
    wr(IPF_IDX_CTRL4, 16'h0004);
    for (int c = 0; c < 8; c++) begin
      wr(IPF_IDX_CTRL3, {1'b0, c[2:0], 12'h000});
      @(posedge clk_i);
      #1;
      // Tie at 4 goes to the lower source number
      src = (c >= 4) ? 4'h3 : 4'h8;
      lvl = (c >= 4) ? c[2:0] : 3'h4;
      chk("take", {24'h0, 1'b1, src, lvl}, {24'h0, take_w});
      rd(IPF_IDX_TAKE, {7'h00, 1'b1, src, 1'b0, lvl});
    end
    // Enable and pending gate the choice; change notify sits at 7
    @(posedge clk_i);
    src_en_i <= 9'h1F7;
    @(posedge clk_i);
    @(posedge clk_i);
    #1;
    chk("take_en", {24'h0, 8'hC4}, {24'h0, take_w});
    @(posedge clk_i);
    src_en_i <= 9'h1FF;
    src_pend_i <= 9'h1F7;
    @(posedge clk_i);
    @(posedge clk_i);
    #1;
    chk("take_pend", {24'h0, 8'hC4}, {24'h0, take_w});
    @(posedge clk_i);
    src_pend_i <= 9'h1FF;
    // A lone source at code 001 is still taken
    wr(IPF_IDX_CTRL4, 16'h0000);
    wr(IPF_IDX_CTRL3, 16'h1000);
    @(posedge clk_i);
    #1;
    chk("take_min", {24'h0, 8'h99}, {24'h0, take_w});
    wr(IPF_IDX_CTRL3, 16'h0000);
    @(posedge clk_i);
    #1;
    chk("take_off", 32'h0, {24'h0, take_w});
    rd(IPF_IDX_OFF, 16'h01FF);
    // Second reset in mid-run restores every field
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk("fields_rst", {5'h00, {9{3'h4}}}, {5'h00, all_f});
    chk("take_rst2", 32'h0, {24'h0, take_w});
    rd(IPF_IDX_CTRL4, 16'h0404);
    finish_test();
  end
endmodule
`default_nettype wire
